// [etq_defines.vh]
// Register map, field positions, reset values and timing for the trigger qualifier
// Assumes a 125 MHz board clock and 32-bit APB data
`ifndef ETQ_DEFINES_VH
`define ETQ_DEFINES_VH

`define ETQ_CLK_PERIOD_NS 8
`define ETQ_NS_PER_US 1000
`define ETQ_CYC_PER_US (`ETQ_NS_PER_US / `ETQ_CLK_PERIOD_NS)

`define ETQ_ADDR_CTRL 8'h00
`define ETQ_ADDR_RESERVE 8'h04
`define ETQ_ADDR_MIN_PULSE 8'h08
`define ETQ_ADDR_FRAME_COUNT 8'h0C
`define ETQ_ADDR_DELAY 8'h10
`define ETQ_ADDR_IGNORE 8'h14
`define ETQ_ADDR_STATUS 8'h18

`define ETQ_CTRL_EN 0
`define ETQ_CTRL_DET_LSB 1
`define ETQ_CTRL_SRC_LSB 4
`define ETQ_CTRL_TB_LSB 8
`define ETQ_CTRL_ANALOG 10

`define ETQ_DET_LEVEL_LOW 3'h0
`define ETQ_DET_LEVEL_HIGH 3'h1
`define ETQ_DET_RISING 3'h2
`define ETQ_DET_FALLING 3'h3
`define ETQ_DET_DUAL_RISING 3'h4
`define ETQ_DET_DUAL_FALLING 3'h5

`define ETQ_TB_LINES 2'h0
`define ETQ_TB_NS 2'h1
`define ETQ_TB_LINE_OR_SHAFT 2'h2
`define ETQ_TB_SHAFT 2'h3

`define ETQ_STAT_BUSY 0
`define ETQ_STAT_IGNORE 3
`define ETQ_STAT_ACTIVE 4
`define ETQ_STAT_CFG_ERR 5

`define ETQ_RST_CTRL 32'h00000004
`define ETQ_RST_RESERVE 32'h00000003
`define ETQ_RST_MIN_PULSE 32'h00000000
`define ETQ_RST_FRAME_COUNT 32'h00000001
`define ETQ_RST_DELAY 32'h00000000
`define ETQ_RST_IGNORE 32'h00000000

`define ETQ_FRAME_COUNT_MIN 32'h00000001
`define ETQ_FRAME_COUNT_MAX 32'h0003FFFE
`define ETQ_IGNORE_MAX_US 32'h028F5C28

`endif

// [etq_sync.v]
// Two-flop synchroniser for a group of asynchronous pins
// Assumes each bit is an independent level; no bus coherence is kept
`timescale 1ns/1ns
`default_nettype none
module etq_sync #(
   parameter WIDTH = 6
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else if (clk_en) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // etq_sync
`default_nettype wire

// [etq_tick.v]
// Divider giving one-cycle pulses at a fixed period of board clocks
// Assumes clk_en gates the divider together with the rest of the block
`timescale 1ns/1ns
`default_nettype none
module etq_tick #(
   parameter DIV = 125
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   output reg tick
);
   reg [15:0] cnt;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (clk_en) begin
         if (cnt == DIV[15:0] - 16'h0001) begin
            cnt <= 16'h0000;
            tick <= 1'b1;
         end else begin
            cnt <= cnt + 16'h0001;
            tick <= 1'b0;
         end
      end
   end
endmodule // etq_tick
`default_nettype wire

// [etq_trig_src.sv]
// Model of the external trigger source wired to the qualifier pins
// Assumes pins idle at the inactive level chosen by inv
`timescale 1ns/1ns
`default_nettype none
module etq_trig_src (
   input wire logic clk,
   input wire logic inv,
   output logic [3:0] pins
);
   logic [3:0] act = 4'h0;
   assign pins = act ^ {4{inv}};
   // Caller enters just after a rising edge; one pin is active for w clocks
   task automatic pulse(input int idx, input int w);
      act[idx] <= 1'b1;
      repeat (w) @(posedge clk);
      act[idx] <= 1'b0;
      @(posedge clk);
   endtask
endmodule // etq_trig_src
`default_nettype wire

// [etq_trigger_qualifier.v]
// External frame trigger qualifier with APB register file
// Assumes trigger pins are asynchronous; frame_valid, vsync_end, cam_line_pulse
// and frame_ack come from logic on ref_clk
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "etq_defines.vh"
// How it works
// - Frames start only after an accepted trigger when enabled; disabled ignores triggers.
// - Level mode requests frames continuously while input holds the chosen level.
// - Rising or falling edge mode captures at most one trigger per qualifying transition; one arriving while busy or ignoring is lost.
// - Dual-input rising and falling edge modes use the selected input and its partner.
// - Trigger comes from a selectable input; inputs 0 and 1 reserved by default.
// - Pulses shorter than the minimum duration in microseconds are discarded.
// - A minimum duration of zero accepts every detected trigger immediately.
// - Each edge-mode trigger acquires the configured frame count, accepted only within 1 to 262142.
// - Minus one, endless acquisition, is refused as a frame count.
// - Acquisition waits the configured delay after a trigger is accepted.
// - Delay time base is line counts, nanoseconds, line trigger or shaft, or shaft.
// - Triggers inside the ignore window after a valid trigger are dropped; 0 to 42949672 us.
// - Window starts at first frame valid (digital) or end of vertical sync (analog).
module etq_trigger_qualifier #(
   parameter NUM_IN = 4,
   parameter SRC_W = 2
) (
   input wire ref_clk,
   input wire reset_n,
   input wire clk_en,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [NUM_IN-1:0] trigger_pins,
   input wire ext_line_pin,
   input wire shaft_enc_pin,
   input wire cam_line_pulse,
   input wire frame_valid,
   input wire vsync_end,
   input wire frame_ack,
   output reg frame_req,
   output reg trigger_accepted,
   output reg acq_busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_DELAY = 2'h1;
   localparam ST_REQ = 2'h2;
   localparam [31:0] RST_CTRL = `ETQ_RST_CTRL, RST_RES = `ETQ_RST_RESERVE;
   localparam [31:0] RST_MIN = `ETQ_RST_MIN_PULSE, RST_FC = `ETQ_RST_FRAME_COUNT;
   reg [1:0] rst_pipe;
   wire rst_n;
   wire [NUM_IN+1:0] sync_q;
   wire us_tick;
   reg cfg_en;
   reg [2:0] cfg_det;
   reg [SRC_W-1:0] cfg_src;
   reg [1:0] cfg_tb;
   reg cfg_analog;
   reg [NUM_IN-1:0] reserve;
   reg [15:0] min_us;
   reg [17:0] frame_count;
   reg [31:0] delay_val;
   reg [31:0] ignore_us;
   reg cfg_err;
   reg [1:0] state;
   reg [17:0] remain;
   reg [31:0] dly_cnt;
   reg [15:0] pw_cnt;
   reg taken;
   reg [1:0] ign_state;
   reg [31:0] ign_cnt;
   reg prev_line;
   reg prev_shaft;
   reg prev_fv;
   function pick;
      input [NUM_IN-1:0] v;
      input [SRC_W-1:0] idx;
      begin
         pick = v[idx];
      end
   endfunction
   // Reset released through two flops so every flop leaves reset on the same edge
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_pipe <= 2'h0;
      end else if (clk_en) begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];
   etq_sync #(.WIDTH(NUM_IN + 2)) u_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .d({shaft_enc_pin, ext_line_pin, trigger_pins}),
      .q(sync_q)
   );

   etq_tick #(.DIV(`ETQ_CYC_PER_US)) u_us_tick (
      .clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .tick(us_tick)
   );
   wire [NUM_IN-1:0] trig_sync = sync_q[NUM_IN-1:0];
   wire line_sync = sync_q[NUM_IN];
   wire shaft_sync = sync_q[NUM_IN+1];
   wire line_edge = line_sync & ~prev_line;
   wire shaft_edge = shaft_sync & ~prev_shaft;
   wire fv_start = frame_valid & ~prev_fv;
   // Active level after polarity; low level and falling edges look for a low pin
   wire inv = (cfg_det == `ETQ_DET_LEVEL_LOW) || (cfg_det == `ETQ_DET_FALLING) ||
              (cfg_det == `ETQ_DET_DUAL_FALLING);
   wire is_level = (cfg_det == `ETQ_DET_LEVEL_LOW) || (cfg_det == `ETQ_DET_LEVEL_HIGH);
   wire is_dual = (cfg_det == `ETQ_DET_DUAL_RISING) || (cfg_det == `ETQ_DET_DUAL_FALLING);
   wire [SRC_W-1:0] partner = cfg_src ^ {{(SRC_W-1){1'b0}}, 1'b1};
   // An unreserved input can never become active
   wire act_a = pick(reserve, cfg_src) & (pick(trig_sync, cfg_src) ^ inv);
   wire act_b = is_dual & pick(reserve, partner) & (pick(trig_sync, partner) ^ inv);
   wire act = cfg_en & (act_a | act_b);
   wire qual = act & ((min_us == 16'h0000) || (pw_cnt >= min_us));
   wire edge_fire = ~is_level & qual & ~taken;
   wire lvl_hold = is_level & qual;
   wire ign_blk = (ign_state != 2'h0);
   wire start = (state == ST_IDLE) & ~ign_blk & (edge_fire | lvl_hold);
   reg [31:0] dly_step;
   always @* begin
      case (cfg_tb)
         `ETQ_TB_LINES: dly_step = {31'h00000000, cam_line_pulse};
         `ETQ_TB_NS: dly_step = `ETQ_CLK_PERIOD_NS;
         `ETQ_TB_LINE_OR_SHAFT: dly_step = {31'h00000000, line_edge | shaft_edge};
         `ETQ_TB_SHAFT: dly_step = {31'h00000000, shaft_edge};
         default: dly_step = 32'h00000000;
      endcase
   end

   // Pulse width in microseconds; saturates so long pulses stay qualified
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pw_cnt <= 16'h0000;
         taken <= 1'b0;
         prev_line <= 1'b0;
         prev_shaft <= 1'b0;
         prev_fv <= 1'b0;
      end else if (clk_en) begin
         prev_line <= line_sync;
         prev_shaft <= shaft_sync;
         prev_fv <= frame_valid;
         if (!act) begin
            pw_cnt <= 16'h0000;
            taken <= 1'b0;
         end else begin
            if (us_tick && pw_cnt != 16'hFFFF) begin
               pw_cnt <= pw_cnt + 16'h0001;
            end
            // Each transition is used once, even if dropped while busy or ignoring
            if (edge_fire) begin
               taken <= 1'b1;
            end
         end
      end
   end

   // Acquisition sequencer: delay, then one frame request per acknowledge
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         remain <= 18'h00000;
         dly_cnt <= 32'h00000000;
         frame_req <= 1'b0;
         trigger_accepted <= 1'b0;
         acq_busy <= 1'b0;
      end else if (clk_en) begin
         trigger_accepted <= start;
         case (state)
            ST_IDLE: begin
               acq_busy <= start;
               if (start) begin
                  remain <= frame_count;
                  dly_cnt <= 32'h00000000;
                  state <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (dly_cnt >= delay_val) begin
                  state <= ST_REQ;
                  frame_req <= 1'b1;
               end else begin
                  dly_cnt <= dly_cnt + dly_step;
               end
            end
            ST_REQ: begin
               if (frame_ack) begin
                  remain <= remain - 18'h00001;
                  if (is_level ? lvl_hold : (remain != 18'h00001)) begin
                     frame_req <= 1'b1;
                  end else begin
                     frame_req <= 1'b0;
                     acq_busy <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               frame_req <= 1'b0;
               acq_busy <= 1'b0;
            end
         endcase
      end
   end

   // Ignore window: armed by an accepted trigger, counting from the first frame
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ign_state <= 2'h0;
         ign_cnt <= 32'h00000000;
      end else if (clk_en) begin
         case (ign_state)
            2'h0: begin
               if (start && ignore_us != 32'h00000000) begin
                  ign_state <= 2'h1;
               end
            end
            2'h1: begin
               if (cfg_analog ? vsync_end : fv_start) begin
                  ign_state <= 2'h2;
                  ign_cnt <= 32'h00000000;
               end
            end
            2'h2: begin
               if (ign_cnt >= ignore_us) begin
                  ign_state <= 2'h0;
               end else if (us_tick) begin
                  ign_cnt <= ign_cnt + 32'h00000001;
               end
            end
            default: ign_state <= 2'h0;
         endcase
      end
   end

   // APB slave: no wait states; read data is captured in the setup cycle
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire mapped = (paddr == `ETQ_ADDR_CTRL) || (paddr == `ETQ_ADDR_RESERVE) ||
                 (paddr == `ETQ_ADDR_MIN_PULSE) || (paddr == `ETQ_ADDR_FRAME_COUNT) ||
                 (paddr == `ETQ_ADDR_DELAY) || (paddr == `ETQ_ADDR_IGNORE) ||
                 (paddr == `ETQ_ADDR_STATUS);
   // Out-of-range counts, including all ones, are refused and leave the old value
   wire fc_bad = (pwdata < `ETQ_FRAME_COUNT_MIN) || (pwdata > `ETQ_FRAME_COUNT_MAX);
   wire ign_bad = (pwdata > `ETQ_IGNORE_MAX_US);
   wire wr_bad = pwrite & (((paddr == `ETQ_ADDR_FRAME_COUNT) & fc_bad) |
                           ((paddr == `ETQ_ADDR_IGNORE) & ign_bad));
   assign pready = 1'b1;
   assign pslverr = acc & (~mapped | wr_bad);

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_en <= RST_CTRL[`ETQ_CTRL_EN];
         cfg_det <= RST_CTRL[`ETQ_CTRL_DET_LSB +: 3];
         cfg_src <= RST_CTRL[`ETQ_CTRL_SRC_LSB +: SRC_W];
         cfg_tb <= RST_CTRL[`ETQ_CTRL_TB_LSB +: 2];
         cfg_analog <= RST_CTRL[`ETQ_CTRL_ANALOG];
         reserve <= RST_RES[NUM_IN-1:0];
         min_us <= RST_MIN[15:0];
         frame_count <= RST_FC[17:0];
         delay_val <= `ETQ_RST_DELAY;
         ignore_us <= `ETQ_RST_IGNORE;
         cfg_err <= 1'b0;
      end else if (clk_en) begin
         if (wr) begin
            case (paddr)
               `ETQ_ADDR_CTRL: begin
                  cfg_en <= pwdata[`ETQ_CTRL_EN];
                  cfg_det <= pwdata[`ETQ_CTRL_DET_LSB +: 3];
                  cfg_src <= pwdata[`ETQ_CTRL_SRC_LSB +: SRC_W];
                  cfg_tb <= pwdata[`ETQ_CTRL_TB_LSB +: 2];
                  cfg_analog <= pwdata[`ETQ_CTRL_ANALOG];
               end
               `ETQ_ADDR_RESERVE: reserve <= pwdata[NUM_IN-1:0];
               `ETQ_ADDR_MIN_PULSE: min_us <= pwdata[15:0];
               `ETQ_ADDR_FRAME_COUNT: begin
                  if (!fc_bad) begin
                     frame_count <= pwdata[17:0];
                  end
               end
               `ETQ_ADDR_DELAY: delay_val <= pwdata;
               `ETQ_ADDR_IGNORE: begin
                  if (!ign_bad) begin
                     ignore_us <= pwdata;
                  end
               end
               `ETQ_ADDR_STATUS: begin
                  if (pwdata[`ETQ_STAT_CFG_ERR]) begin
                     cfg_err <= 1'b0;
                  end
               end
               default: cfg_err <= cfg_err;
            endcase
         end
         // A refused write sets the flag after any clear in the same cycle
         if (wr && wr_bad) begin
            cfg_err <= 1'b1;
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `ETQ_ADDR_CTRL: begin
                  prdata <= 32'h00000000;
                  prdata[`ETQ_CTRL_EN] <= cfg_en;
                  prdata[`ETQ_CTRL_DET_LSB +: 3] <= cfg_det;
                  prdata[`ETQ_CTRL_SRC_LSB +: SRC_W] <= cfg_src;
                  prdata[`ETQ_CTRL_TB_LSB +: 2] <= cfg_tb;
                  prdata[`ETQ_CTRL_ANALOG] <= cfg_analog;
               end
               `ETQ_ADDR_RESERVE: prdata <= {{(32-NUM_IN){1'b0}}, reserve};
               `ETQ_ADDR_MIN_PULSE: prdata <= {16'h0000, min_us};
               `ETQ_ADDR_FRAME_COUNT: prdata <= {14'h0000, frame_count};
               `ETQ_ADDR_DELAY: prdata <= delay_val;
               `ETQ_ADDR_IGNORE: prdata <= ignore_us;
               `ETQ_ADDR_STATUS: begin
                  prdata <= {remain, 6'h00, 2'h0, cfg_err, act, ign_blk, state, acq_busy};
               end
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // etq_trigger_qualifier
`default_nettype wire

// [etq_trigger_qualifier_sva.sv]
// Checker for the trigger qualifier, bound to its top module
// Assumes single clock ref_clk and active-low reset_n
`timescale 1ns/1ns
`default_nettype none
`include "etq_defines.vh"
module etq_trigger_qualifier_sva (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic frame_ack,
   input wire logic frame_req,
   input wire logic trigger_accepted,
   input wire logic acq_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire wr = psel && penable && pwrite;
   property p_fc_range;
      wr && paddr == `ETQ_ADDR_FRAME_COUNT && (pwdata == 32'h0 || pwdata > `ETQ_FRAME_COUNT_MAX)
         |-> pslverr;
   endproperty
   a_fc_range: assert property (p_fc_range) else $error("bad frame count taken");
   property p_fc_endless;
      wr && paddr == `ETQ_ADDR_FRAME_COUNT && pwdata == 32'hFFFFFFFF |-> pslverr;
   endproperty
   a_fc_endless: assert property (p_fc_endless) else $error("endless count taken");
   property p_ign_range;
      wr && paddr == `ETQ_ADDR_IGNORE && pwdata > `ETQ_IGNORE_MAX_US |-> pslverr;
   endproperty
   a_ign_range: assert property (p_ign_range) else $error("bad ignore taken");
   property p_req_hold;
      frame_req && !frame_ack |=> frame_req;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_acc_pulse;
      trigger_accepted |=> !trigger_accepted;
   endproperty
   a_acc_pulse: assert property (p_acc_pulse) else $error("accept pulse too long");
   property p_busy_cause;
      $rose(acq_busy) |-> trigger_accepted;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
   property p_req_after;
      $rose(frame_req) |-> $past(acq_busy) && !trigger_accepted;
   endproperty
   a_req_after: assert property (p_req_after) else $error("request too soon");
   property p_req_busy;
      frame_req |-> acq_busy;
   endproperty
   a_req_busy: assert property (p_req_busy) else $error("request while idle");
   property p_busy_end;
      $fell(acq_busy) |-> $past(frame_ack);
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy ended without ack");
endmodule // etq_trigger_qualifier_sva
bind etq_trigger_qualifier etq_trigger_qualifier_sva chk_i (.ref_clk(ref_clk),
   .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pslverr(pslverr), .frame_ack(frame_ack), .frame_req(frame_req),
   .trigger_accepted(trigger_accepted), .acq_busy(acq_busy));
`default_nettype wire

// [etq_trigger_qualifier_tb.sv]
// Self-checking bench: APB register checks and trigger scenarios
// Assumes the source model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`include "etq_defines.vh"
module etq_trigger_qualifier_tb;
   logic ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h2C43E7CA;
   logic pready, pslverr, frame_req, trigger_accepted, acq_busy, inv = 1'b0, req_d = 1'b0;
   logic frame_ack = 1'b0, frame_valid = 1'b0, cam_line = 1'b0, ext_line = 1'b0, shaft = 1'b0;
   logic [3:0] pins;
   int n_errors = 0, checks_done = 0, n_acc = 0, n_ack = 0, cyc = 0, t_acc = 0, t_req = 0;
   int fr, i, fc;
   always #4 ref_clk = ~ref_clk;
   etq_trig_src src (.clk(ref_clk), .inv(inv), .pins(pins));
   etq_trigger_qualifier dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_pins(pins),
      .ext_line_pin(ext_line), .shaft_enc_pin(shaft), .cam_line_pulse(cam_line),
      .frame_valid(frame_valid), .vsync_end(frame_ack), .frame_ack(frame_ack),
      .frame_req(frame_req), .trigger_accepted(trigger_accepted), .acq_busy(acq_busy));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] ctl(input int en, det, s, t, an);
      return en | (det << `ETQ_CTRL_DET_LSB) | (s << `ETQ_CTRL_SRC_LSB)
         | (t << `ETQ_CTRL_TB_LSB) | (an << `ETQ_CTRL_ANALOG);
   endfunction
   // Sequencer side acks at random moments, so frame pacing is not fixed
   always @(posedge ref_clk) begin
      lfsr <= nx(lfsr);
      frame_ack <= frame_req && !frame_ack && lfsr[3];
      frame_valid <= frame_ack;
      cam_line <= lfsr[5];
      ext_line <= lfsr[7];
      shaft <= lfsr[9];
      n_acc <= n_acc + trigger_accepted;
      n_ack <= n_ack + (frame_ack && frame_req);
      cyc <= cyc + 1;
      req_d <= frame_req;
      if (trigger_accepted) t_acc <= cyc;
      if (frame_req && !req_d) t_req <= cyc;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
      int k;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         chk("pready", 1, 0);
         close_out();
      end
      if (!wr) chk("prdata", d, prdata);
      chk("pslverr", {31'h0, e}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic cfg(input int det, s, t, an);
      apb(1, `ETQ_ADDR_CTRL, ctl(0, det, s, t, an), 0);
      inv <= (det == 0 || det == 3 || det == 5);
      apb(1, `ETQ_ADDR_CTRL, ctl(1, det, s, t, an), 0);
   endtask
   // A negative expectation skips that compare
   task automatic trig(input string nm, input int idx, w, ea, ef);
      int a0, f0, k;
      a0 = n_acc;
      f0 = n_ack;
      src.pulse(idx, w);
      repeat (30) @(posedge ref_clk);
      for (k = 0; k < 20000 && acq_busy !== 1'b0; k++) @(posedge ref_clk);
      if (k >= 20000) begin
         chk("idle", 0, 1);
         close_out();
      end
      repeat (4) @(posedge ref_clk);
      fr = n_ack - f0;
      if (ea >= 0) chk({nm, " accepted"}, ea, n_acc - a0);
      if (ef >= 0) chk({nm, " frames"}, ef, fr);
      $display("done %s", nm);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      apb(0, `ETQ_ADDR_CTRL, `ETQ_RST_CTRL, 0);
      apb(0, `ETQ_ADDR_RESERVE, `ETQ_RST_RESERVE, 0);
      apb(0, `ETQ_ADDR_MIN_PULSE, `ETQ_RST_MIN_PULSE, 0);
      apb(0, `ETQ_ADDR_DELAY, `ETQ_RST_DELAY, 0);
      apb(0, `ETQ_ADDR_IGNORE, `ETQ_RST_IGNORE, 0);
      apb(0, 8'h40, 32'h0, 1);
      apb(1, `ETQ_ADDR_FRAME_COUNT, 32'h0, 1);
      apb(1, `ETQ_ADDR_FRAME_COUNT, `ETQ_FRAME_COUNT_MAX + 1, 1);
      apb(1, `ETQ_ADDR_FRAME_COUNT, 32'hFFFFFFFF, 1);
      apb(0, `ETQ_ADDR_FRAME_COUNT, `ETQ_RST_FRAME_COUNT, 0);
      apb(1, `ETQ_ADDR_IGNORE, `ETQ_IGNORE_MAX_US + 1, 1);
      apb(1, `ETQ_ADDR_IGNORE, `ETQ_IGNORE_MAX_US, 0);
      apb(1, `ETQ_ADDR_IGNORE, 32'h0, 0);
      apb(0, `ETQ_ADDR_STATUS, 32'h00000001 << `ETQ_STAT_CFG_ERR, 0);
      apb(1, `ETQ_ADDR_STATUS, 32'h00000001 << `ETQ_STAT_CFG_ERR, 0);
      apb(0, `ETQ_ADDR_STATUS, 32'h00000000, 0);
      trig("disabled", 0, 8, 0, 0);
      for (i = 0; i < 6; i++) begin
         fc = lfsr[1:0] + 1;
         apb(1, `ETQ_ADDR_FRAME_COUNT, fc, 0);
         cfg(2 + i % 2, i % 2, 0, 0);
         trig("edge", i % 2, 2 + lfsr[3:0], 1, fc);
      end
      cfg(2, 2, 0, 0);
      trig("unreserved", 2, 8, 0, 0);
      apb(1, `ETQ_ADDR_RESERVE, 32'hF, 0);
      trig("reserved", 2, 8, 1, fc);
      for (i = 4; i < 6; i++) begin
         cfg(i, 0, 0, 0);
         trig("dual", 1, 8, 1, fc);
      end
      apb(1, `ETQ_ADDR_MIN_PULSE, 32'h2, 0);
      trig("short", 0, 120, 0, 0);
      trig("long", 0, 400, 1, fc);
      apb(1, `ETQ_ADDR_MIN_PULSE, 32'h0, 0);
      for (i = 0; i < 2; i++) begin
         cfg(i, 0, 0, 0);
         trig("level", 0, 300, -1, -1);
         chk("level repeats", 1, fr > 1);
      end
      apb(1, `ETQ_ADDR_FRAME_COUNT, 32'h1, 0);
      for (i = 0; i < 4; i++) begin
         cfg(2, 0, i, 0);
         apb(1, `ETQ_ADDR_DELAY, (i == 1) ? 800 : 3, 0);
         trig("delay", 0, 6, 1, 1);
         fr = t_req - t_acc;
         chk("delay", 1, (i == 1) ? (fr inside {[100:103]}) : (fr > 3));
      end
      apb(1, `ETQ_ADDR_DELAY, 32'h0, 0);
      apb(1, `ETQ_ADDR_IGNORE, 32'h00000014, 0);
      for (i = 0; i < 2; i++) begin
         cfg(2, 0, 0, i);
         trig("first", 0, 6, 1, 1);
         trig("ignored", 0, 6, 0, 0);
         repeat (2600) @(posedge ref_clk);
         trig("after window", 0, 6, 1, 1);
         // The accepted trigger above opens a fresh window; let it expire
         repeat (2600) @(posedge ref_clk);
      end
      close_out();
   end
endmodule // etq_trigger_qualifier_tb
`default_nettype wire
